// ### bkrg_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R1) Latch at 00h, zero reset, read clears
// (R2) Sense at 01h shows live conditions
// (R3) Reserved and test addresses hold nothing
// (R4) Good/discharge register 12h resets 11h
// (R5) Timing register 13h resets 19h
// (R6) Mode command register 14h resets 8Dh
// (R7) Limit register 16h resets E3h
// (R8) Target 17h used when select high
// (R9) Target 18h used when select low
// (R10) Pointer auto-increments for writes and reads
// (R11) Reserved locations have no storage
// (R12) Read-only/reserved writes ignored, reserved reads zero
module bkrg_regs (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Protocol engine side
    input wire logic ptr_load_i,
    input wire logic [7:0] ptr_addr_i,
    input wire logic wr_stb_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_stb_i,
    // Pins and conditions
    input wire logic voltage_select_pin_i,
    input wire logic [7:0] condition_i,
    // Read data and register outputs
    output logic [7:0] rd_data_o,
    output logic [7:0] output_good_discharge_cfg_o,
    output logic [7:0] enable_ramp_timing_o,
    output logic [7:0] operating_mode_control_o,
    output logic [7:0] limit_reset_config_o,
    output logic [7:0] vout_target_o
);

    // ----------------------------------------
    // Condition synchroniser
    // ----------------------------------------
    bkrg_if cond_if ();
    assign cond_if.raw = condition_i;
    bkrg_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .clk_en_i(clk_en_i),
        .bus(cond_if.sync)
    );

    // ----------------------------------------
    // Internal state
    // ----------------------------------------
    logic [7:0] live;
    logic [7:0] live_q;
    logic [7:0] events;
    logic voltage_select_pin_s1;
    logic voltage_select_pin_s2;
    logic [7:0] pointer;
    logic [7:0] interrupt_latch;
    logic [7:0] next_interrupt_latch;
    logic [7:0] read_value;
    logic [7:0] next_pointer;
    logic wr_take;
    logic rd_take;

    function automatic logic [7:0] bump(input logic [7:0] a);
        bump = a + bkrg_pkg::ADDR_STEP;
    endfunction

    // ----------------------------------------
    // Request qualifiers and event detect
    // ----------------------------------------
    // A pointer load beats a strobe in the same cycle
    assign wr_take = clk_en_i && wr_stb_i && !ptr_load_i;
    assign rd_take = clk_en_i && rd_stb_i && !ptr_load_i;
    // Spare bit forced low so it never raises an event
    assign live = cond_if.synced & bkrg_pkg::EVENT_SPARE_MASK;
    // Both polarities of a condition change count
    assign events = live ^ live_q;

    // ----------------------------------------
    // Select pin synchroniser
    // ----------------------------------------
    // Only the second stage is read, the first may be metastable
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            voltage_select_pin_s1 <= 1'b0;
            voltage_select_pin_s2 <= 1'b0;
        end else if (clk_en_i) begin
            voltage_select_pin_s1 <= voltage_select_pin_i;
            voltage_select_pin_s2 <= voltage_select_pin_s1;
        end
    end
    // Previous live value for edge detection
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            live_q <= 8'h00;
        end else if (clk_en_i) begin
            live_q <= live;
        end
    end

    // ----------------------------------------
    // Register pointer
    // ----------------------------------------
    // Plain 8-bit overflow wraps ffh to 00h
    always_comb begin
        next_pointer = pointer;
        if (ptr_load_i) begin
            next_pointer = ptr_addr_i;
        end else if (wr_stb_i || rd_stb_i) begin
            next_pointer = bump(pointer); // R10
        end
    end
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pointer <= 8'h00;
        end else if (clk_en_i) begin
            pointer <= next_pointer;
        end
    end

    // ----------------------------------------
    // Interrupt latch
    // ----------------------------------------
    // Set wins over the read clear, so no event is lost
    always_comb begin
        next_interrupt_latch = interrupt_latch | events;
        if (rd_take && pointer == bkrg_pkg::ADDR_INTERRUPT_LATCH) begin
            next_interrupt_latch = events; // R1
        end
    end
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            interrupt_latch <= bkrg_pkg::RST_INTERRUPT_LATCH; // R1
        end else if (clk_en_i) begin
            interrupt_latch <= next_interrupt_latch; // R1
        end
    end

    // ----------------------------------------
    // Writable registers
    // ----------------------------------------
    logic [7:0] voltage_select_pin_high;
    logic [7:0] voltage_select_pin_low;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            output_good_discharge_cfg_o <= bkrg_pkg::RST_OUTPUT_GOOD_DISCHARGE_CFG; // R4
            enable_ramp_timing_o <= bkrg_pkg::RST_ENABLE_RAMP_TIMING; // R5
            operating_mode_control_o <= bkrg_pkg::RST_OPERATING_MODE_CONTROL; // R6
            limit_reset_config_o <= bkrg_pkg::RST_LIMIT_RESET_CONFIG; // R7
            voltage_select_pin_high <= bkrg_pkg::RST_VOUT_TARGET_SELECT_HIGH;
            voltage_select_pin_low <= bkrg_pkg::RST_VOUT_TARGET_SELECT_LOW;
        end else if (wr_take) begin
            // Other addresses have no storage, so writes there vanish
            unique case (pointer)
                bkrg_pkg::ADDR_OUTPUT_GOOD_DISCHARGE_CFG: begin
                    output_good_discharge_cfg_o <= wr_data_i; // R4
                end
                bkrg_pkg::ADDR_ENABLE_RAMP_TIMING: begin
                    enable_ramp_timing_o <= wr_data_i; // R5
                end
                bkrg_pkg::ADDR_OPERATING_MODE_CONTROL: begin
                    operating_mode_control_o <= wr_data_i; // R6
                end
                bkrg_pkg::ADDR_LIMIT_RESET_CONFIG: begin
                    limit_reset_config_o <= wr_data_i; // R7
                end
                bkrg_pkg::ADDR_VOUT_TARGET_SELECT_HIGH: begin
                    voltage_select_pin_high <= wr_data_i;
                end
                bkrg_pkg::ADDR_VOUT_TARGET_SELECT_LOW: begin
                    voltage_select_pin_low <= wr_data_i;
                end
                default: begin
                end // R11 R12
            endcase
        end
    end

    // ----------------------------------------
    // Target selection
    // ----------------------------------------
    // Pin changes reach the target three cycles later
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            vout_target_o <= bkrg_pkg::RST_VOUT_TARGET_SELECT_LOW;
        end else if (clk_en_i) begin
            vout_target_o <= voltage_select_pin_s2 ? voltage_select_pin_high : voltage_select_pin_low; // R8 R9
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    // Holes in the map read as zero
    always_comb begin
        unique case (pointer)
            bkrg_pkg::ADDR_INTERRUPT_LATCH: read_value = interrupt_latch;
            bkrg_pkg::ADDR_LIVE_CONDITION_SENSE: read_value = live; // R2
            bkrg_pkg::ADDR_PRODUCT_IDENTITY: read_value = bkrg_pkg::ID_PRODUCT;
            bkrg_pkg::ADDR_REVISION_IDENTITY: read_value = bkrg_pkg::ID_REVISION;
            bkrg_pkg::ADDR_FEATURE_IDENTITY: read_value = bkrg_pkg::ID_FEATURE;
            bkrg_pkg::ADDR_OUTPUT_GOOD_DISCHARGE_CFG: read_value = output_good_discharge_cfg_o;
            bkrg_pkg::ADDR_ENABLE_RAMP_TIMING: read_value = enable_ramp_timing_o;
            bkrg_pkg::ADDR_OPERATING_MODE_CONTROL: read_value = operating_mode_control_o;
            bkrg_pkg::ADDR_LIMIT_RESET_CONFIG: read_value = limit_reset_config_o;
            bkrg_pkg::ADDR_VOUT_TARGET_SELECT_HIGH: read_value = voltage_select_pin_high;
            bkrg_pkg::ADDR_VOUT_TARGET_SELECT_LOW: read_value = voltage_select_pin_low;
            default: read_value = bkrg_pkg::READ_ZERO; // R3 R12
        endcase
    end

    // Data registered at the strobe so the engine shifts a stable byte
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_o <= 8'h00;
        end else if (rd_take) begin
            rd_data_o <= read_value; // R10
        end
    end
endmodule
`default_nettype wire

// ### bkrg_pkg.sv
package bkrg_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_INTERRUPT_LATCH = 8'h00;
    localparam logic [7:0] ADDR_LIVE_CONDITION_SENSE = 8'h01;
    localparam logic [7:0] ADDR_PRODUCT_IDENTITY = 8'h03;
    localparam logic [7:0] ADDR_REVISION_IDENTITY = 8'h04;
    localparam logic [7:0] ADDR_FEATURE_IDENTITY = 8'h05;
    localparam logic [7:0] ADDR_OUTPUT_GOOD_DISCHARGE_CFG = 8'h12;
    localparam logic [7:0] ADDR_ENABLE_RAMP_TIMING = 8'h13;
    localparam logic [7:0] ADDR_OPERATING_MODE_CONTROL = 8'h14;
    localparam logic [7:0] ADDR_LIMIT_RESET_CONFIG = 8'h16;
    localparam logic [7:0] ADDR_VOUT_TARGET_SELECT_HIGH = 8'h17;
    localparam logic [7:0] ADDR_VOUT_TARGET_SELECT_LOW = 8'h18;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_INTERRUPT_LATCH = 8'h00;
    localparam logic [7:0] RST_OUTPUT_GOOD_DISCHARGE_CFG = 8'h11;
    localparam logic [7:0] RST_ENABLE_RAMP_TIMING = 8'h19;
    localparam logic [7:0] RST_OPERATING_MODE_CONTROL = 8'h8d;
    localparam logic [7:0] RST_LIMIT_RESET_CONFIG = 8'he3;
    localparam logic [7:0] RST_VOUT_TARGET_SELECT_HIGH = 8'h28;
    localparam logic [7:0] RST_VOUT_TARGET_SELECT_LOW = 8'h60;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [7:0] EVENT_SPARE_MASK = 8'hef;
    // Identity values are arbitrary
    localparam logic [7:0] ID_PRODUCT = 8'h5a;
    localparam logic [7:0] ID_REVISION = 8'h01;
    localparam logic [7:0] ID_FEATURE = 8'h0c;
    localparam logic [7:0] ADDR_STEP = 8'h01;
endpackage

// ### bkrg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bkrg_if;
    logic [7:0] raw;
    logic [7:0] synced;
    modport src (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

// ### bkrg_sync.sv
`timescale 1ns/1ps
`default_nettype none
module bkrg_sync (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    // Carrier
    bkrg_if.sync bus
);
    logic [7:0] stage1;
    logic [7:0] stage2;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stage1 <= 8'h00;
            stage2 <= 8'h00;
        end else if (clk_en_i) begin
            stage1 <= bus.raw;
            stage2 <= stage1;
        end
    end
    assign bus.synced = stage2;
endmodule
`default_nettype wire

// ### bkrg_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
module bkrg_regs_sva (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Requests
    input wire logic clk_en_i,
    input wire logic ptr_load_i,
    input wire logic [7:0] ptr_addr_i,
    input wire logic wr_stb_i,
    input wire logic [7:0] wr_data_i,
    input wire logic rd_stb_i,
    input wire logic voltage_select_pin_i,
    // Results
    input wire logic [7:0] rd_data_o,
    input wire logic [7:0] output_good_discharge_cfg_o,
    input wire logic [7:0] enable_ramp_timing_o,
    input wire logic [7:0] limit_reset_config_o,
    input wire logic [7:0] vout_target_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence s_ptr(logic [7:0] a);
        clk_en_i && ptr_load_i && ptr_addr_i == a;
    endsequence
    sequence s_wr;
        clk_en_i && wr_stb_i && !ptr_load_i;
    endsequence
    sequence s_rd;
        clk_en_i && rd_stb_i && !ptr_load_i;
    endsequence
    // Pin held still so the select path has settled
    property p_vout(logic [7:0] a, logic lvl);
        s_ptr(a) ##1 s_wr ##0 voltage_select_pin_i == lvl ##1
            (clk_en_i && !wr_stb_i && voltage_select_pin_i == lvl) [*4] |-> vout_target_o == $past(wr_data_i, 4);
    endproperty
    reset_vals_a: assert property ($rose(reset_n_i) |-> output_good_discharge_cfg_o == 8'h11 &&
        enable_ramp_timing_o == 8'h19 && limit_reset_config_o == 8'he3 && vout_target_o == 8'h60) else $error("bad reset");
    good_write_a: assert property (s_ptr(8'h12) ##1 s_wr |=>
        output_good_discharge_cfg_o == $past(wr_data_i)) else $error("12h write lost");
    ramp_incr_a: assert property (s_ptr(8'h12) ##1 s_wr ##1 s_wr |=>
        enable_ramp_timing_o == $past(wr_data_i)) else $error("pointer step lost");
    limit_write_a: assert property (s_ptr(8'h16) ##1 s_wr |=>
        limit_reset_config_o == $past(wr_data_i)) else $error("16h write lost");
    rsvd_read_a: assert property (s_ptr(8'h02) ##1 s_rd |=> rd_data_o == 8'h00) else $error("02h not zero");
    test_read_a: assert property (s_ptr(8'hff) ##1 s_rd |=> rd_data_o == 8'h00) else $error("ffh not zero");
    vout_high_a: assert property (p_vout(8'h17, 1'b1)) else $error("high target wrong");
    vout_low_a: assert property (p_vout(8'h18, 1'b0)) else $error("low target wrong");
endmodule
bind bkrg_regs bkrg_regs_sva bkrg_regs_sva_i (.*);
`default_nettype wire

// ### bkrg_host.sv
`timescale 1ns/1ps
`default_nettype none
module bkrg_host (
    // Clock
    input wire logic clk_i,
    // Requests
    output logic ptr_load_o,
    output logic [7:0] ptr_addr_o,
    output logic wr_stb_o,
    output logic [7:0] wr_data_o,
    output logic rd_stb_o,
    // Answer
    input wire logic [7:0] rd_data_i
);
    initial begin
        ptr_load_o = 1'b0;
        ptr_addr_o = 8'h00;
        wr_stb_o = 1'b0;
        wr_data_o = 8'h00;
        rd_stb_o = 1'b0;
    end
    // Idle lines carry the address or its inverse, never the last byte
    task automatic drive(input logic pl, input logic [7:0] a, input logic ws, input logic [7:0] d, input logic rs);
        ptr_load_o <= pl;
        ptr_addr_o <= a;
        wr_stb_o <= ws;
        wr_data_o <= d;
        rd_stb_o <= rs;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
        drive(1'b1, a, 1'b0, ~a, 1'b0);
        foreach (d[i]) drive(1'b0, ~a, 1'b1, d[i], 1'b0);
        drive(1'b0, a, 1'b0, ~a, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[$]);
        q = {};
        drive(1'b1, a, 1'b0, ~a, 1'b0);
        for (int i = 0; i < n; i++) begin
            drive(1'b0, ~a, 1'b0, a, 1'b1);
            // Answer to the previous strobe stands at this edge
            if (i > 0) q.push_back(rd_data_i);
        end
        drive(1'b0, a, 1'b0, ~a, 1'b0);
        q.push_back(rd_data_i);
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic clk_en_i = 1'b1;
    logic voltage_select_pin_i = 1'b0;
    logic [7:0] condition_i = 8'h00;
    logic ptr_load_i, wr_stb_i, rd_stb_i;
    logic [7:0] ptr_addr_i, wr_data_i, rd_data_o, output_good_discharge_cfg_o, enable_ramp_timing_o;
    logic [7:0] operating_mode_control_o, limit_reset_config_o, vout_target_o;
    logic [7:0] q[$];
    logic [7:0] rsv[$] = '{8'h02, 8'h03, 8'h06, 8'h11, 8'h15, 8'h19, 8'h26, 8'h27, 8'hff};
    logic [7:0] rst_tab[$] = '{8'h11, 8'h19, 8'h8d, 8'h00, 8'he3, 8'h28, 8'h60};
    logic [7:0] id_tab[$] = '{8'h00, 8'h00, 8'h00, bkrg_pkg::ID_PRODUCT, bkrg_pkg::ID_REVISION, bkrg_pkg::ID_FEATURE};
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;
    always #4 sys_clk_i = ~sys_clk_i;
    bkrg_regs bkrg_regs_i (.*);
    bkrg_host bkrg_host_i (.clk_i(sys_clk_i), .ptr_load_o(ptr_load_i), .ptr_addr_o(ptr_addr_i), .wr_stb_o(wr_stb_i),
        .wr_data_o(wr_data_i), .rd_stb_o(rd_stb_i), .rd_data_i(rd_data_o));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Hang guard, well above the 140 or so cycles needed
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chk(vout_target_o, 8'h60);
        bkrg_host_i.rd(8'h12, 7, q);
        foreach (q[i]) chk(q[i], rst_tab[i]);
        bkrg_host_i.rd(8'h00, 6, q);
        foreach (q[i]) chk(q[i], id_tab[i]);
        bkrg_host_i.wr(8'h12, '{8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6, 8'ha7});
        chk(output_good_discharge_cfg_o, 8'ha1);
        chk(enable_ramp_timing_o, 8'ha2);
        chk(operating_mode_control_o, 8'ha3);
        chk(limit_reset_config_o, 8'ha5);
        bkrg_host_i.rd(8'h12, 7, q);
        foreach (q[i]) chk(q[i], (i == 3) ? 8'h00 : 8'ha1 + 8'(i));
        chk(vout_target_o, 8'ha7);
        foreach (rsv[i]) begin
            bkrg_host_i.wr(rsv[i], '{8'h5c});
            bkrg_host_i.rd(rsv[i], 1, q);
            chk(q[0], (rsv[i] == 8'h03) ? bkrg_pkg::ID_PRODUCT : 8'h00);
        end
        bkrg_host_i.wr(8'h16, '{8'h5e});
        chk(limit_reset_config_o, 8'h5e);
        @(posedge sys_clk_i);
        voltage_select_pin_i <= 1'b1;
        condition_i <= 8'h81;
        bkrg_host_i.wr(8'h17, '{8'h3c});
        repeat (4) @(posedge sys_clk_i);
        chk(vout_target_o, 8'h3c);
        voltage_select_pin_i <= 1'b0;
        bkrg_host_i.wr(8'h18, '{8'h4b});
        repeat (4) @(posedge sys_clk_i);
        chk(vout_target_o, 8'h4b);
        bkrg_host_i.rd(8'h01, 1, q);
        chk(q[0], 8'h81);
        bkrg_host_i.rd(8'h00, 1, q);
        chk(q[0], 8'h81);
        bkrg_host_i.rd(8'h00, 1, q);
        chk(q[0], 8'h00);
        clk_en_i <= 1'b0;
        bkrg_host_i.wr(8'h12, '{8'h77});
        chk(output_good_discharge_cfg_o, 8'ha1);
        clk_en_i <= 1'b1;
        @(posedge sys_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
        chk(limit_reset_config_o, 8'he3);
        report_and_stop();
    end
endmodule
`default_nettype wire
